// file: src/report_consts.svh
`ifndef REPORT_CONSTS_SVH
`define REPORT_CONSTS_SVH

// Command descriptor layout, byte positions.
`define CDB_LEN          12
`define CDB_POS_OPCODE   0
`define CDB_POS_SVC      1
`define CDB_POS_LUN      4
`define CDB_POS_ALLOC    6

// Operation codes and service action.
`define OP_IDENT         8'hA3
`define SA_IDENT         5'h05
`define OP_LUNS          8'hA0

// Parameter data sizes in bytes.
`define ID_HDR_LEN       32'h0000_0004
`define LUN_MIN_ALLOC    32'h0000_0010
`define LUN_DATA_LEN     32'h0000_0010
`define LUN_LIST_LEN     32'h0000_0008

// Status and sense codes.
`define STS_GOOD         8'h00
`define STS_CHECK        8'h02
`define KEY_NONE         4'h0
`define KEY_NOT_READY    4'h2
`define KEY_ILLEGAL      4'h5
`define ASC_NONE         8'h00
`define ASC_INV_FIELD    8'h24
`define ASCQ_INV_FIELD   8'h00

`endif

// file: src/report_pkg.sv
package report_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_STAT = 2'b11
   } state_e;

   typedef enum logic [1:0] {
      K_NONE = 2'b00,
      K_ID   = 2'b01,
      K_LUN  = 2'b10
   } kind_e;

endpackage

// file: src/cdb_capture.sv
`timescale 1ns/1ps
`include "report_consts.svh"

module cdb_capture (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        cdb_valid,
   input  wire logic [7:0]  cdb_byte,
   input  wire logic        cdb_ready,
   output logic             cdb_done,
   output logic [7:0]       opcode,
   output logic [4:0]       svc_action,
   output logic [15:0]      lun_field,
   output logic [31:0]      alloc_len
);
   import report_pkg::*;

   logic [7:0] bytes_q [`CDB_LEN];
   logic [3:0] cnt_q;
   logic       done_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q  <= 4'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (cdb_valid && cdb_ready) begin
            if (cnt_q == 4'(`CDB_LEN - 1)) begin
               cnt_q  <= 4'h0;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end

   // The array holds descriptor bytes only; nothing reads it before a full capture.
   always_ff @(posedge clk) begin
      if (cdb_valid && cdb_ready) begin
         bytes_q[cnt_q] <= cdb_byte;
      end
   end

   // (RL14) big-endian field assembly
   assign opcode     = bytes_q[`CDB_POS_OPCODE];
   assign svc_action = bytes_q[`CDB_POS_SVC][4:0];
   assign lun_field  = {bytes_q[`CDB_POS_LUN], bytes_q[`CDB_POS_LUN + 1]};
   assign alloc_len  = {bytes_q[`CDB_POS_ALLOC], bytes_q[`CDB_POS_ALLOC + 1],
                        bytes_q[`CDB_POS_ALLOC + 2], bytes_q[`CDB_POS_ALLOC + 3]};
   assign cdb_done   = done_q;

endmodule // cdb_capture

// file: src/report_engine.sv
// Operation
// (RL1) Identifier report command returns identifier data.
// (RL2) Nonzero LUN field gives illegal request.
// (RL3) Short allocation truncates identifier data, no error.
// (RL4) Four-byte length leads, identifier bytes follow.
// (RL5) Reported length is never reduced by truncation.
// (RL6) Length starts zero, set only by set.
// (RL7) Identifier is last set value, persistent.
// (RL8) Same identifier for every initiator and port.
// (RL9) Storage not ready gives not-ready check at once.
// (RL10) LUN list command always accepted, ignores reservations.
// (RL11) LUN list allocation under sixteen is illegal.
// (RL12) LUN list truncated to whole fitting entries.
// (RL13) LUN list: length eight, reserved, LUN zero.
// (RL14) Multi-byte fields are most significant byte first.
// (RL15) Passing commands complete with good status.
`timescale 1ns/1ps
`include "report_consts.svh"

module report_engine #(
   parameter logic [7:0] NR_ASC  = 8'h04,
   parameter logic [7:0] NR_ASCQ = 8'h00
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        cdb_valid,
   input  wire logic [7:0]  cdb_byte,
   output logic             cdb_ready,
   output logic             foreign_cmd,
   input  wire logic        nv_ready,
   input  wire logic [31:0] nv_id_len,
   output logic [31:0]      nv_rd_addr,
   input  wire logic [7:0]  nv_rd_data,
   output logic             dout_valid,
   output logic [7:0]       dout_byte,
   output logic             dout_last,
   input  wire logic        dout_ready,
   output logic             sts_valid,
   output logic [7:0]       sts_code,
   output logic [3:0]       sense_key,
   output logic [7:0]       sense_asc,
   output logic [7:0]       sense_ascq
);
   import report_pkg::*;

   function automatic logic [7:0] msb_byte(input logic [31:0] w, input logic [1:0] k);
      msb_byte = w[8'(31 - 8 * k) -: 8];
   endfunction

   function automatic logic [31:0] clip(input logic [32:0] total, input logic [31:0] alloc);
      clip = (total < {1'b0, alloc}) ? total[31:0] : alloc;
   endfunction

   state_e      state_q;
   kind_e       kind_q;
   logic [31:0] idx_q;
   logic [31:0] xfer_len_q;
   logic [31:0] id_len_q;
   logic [31:0] out_idx_q;
   logic        dout_valid_q;
   logic [7:0]  dout_byte_q;
   logic        dout_last_q;
   logic        foreign_q;
   logic [7:0]  sts_code_q;
   logic [3:0]  key_q;
   logic [7:0]  asc_q;
   logic [7:0]  ascq_q;

   logic        cdb_done;
   logic [7:0]  opcode;
   logic [4:0]  svc_action;
   logic [15:0] lun_field;
   logic [31:0] alloc_len;
   logic        is_id;
   logic        is_lun;
   logic        id_lun_bad;
   logic        lun_alloc_bad;
   logic [31:0] id_xfer;
   logic [31:0] lun_xfer;
   logic        load;
   logic        done_send;
   logic [7:0]  next_byte;

   cdb_capture u_cap (
      .clk        (clk),
      .rst        (rst),
      .cdb_valid  (cdb_valid),
      .cdb_byte   (cdb_byte),
      .cdb_ready  (cdb_ready),
      .cdb_done   (cdb_done),
      .opcode     (opcode),
      .svc_action (svc_action),
      .lun_field  (lun_field),
      .alloc_len  (alloc_len)
   );

   // (RL10) no reservation gating
   assign cdb_ready = (state_q == ST_IDLE) && !cdb_done;

   assign is_id         = (opcode == `OP_IDENT) && (svc_action == `SA_IDENT);
   assign is_lun        = (opcode == `OP_LUNS);
   // (RL2) LUN field check
   assign id_lun_bad    = (lun_field != 16'h0000);
   // (RL11) minimum list allocation
   assign lun_alloc_bad = (alloc_len < `LUN_MIN_ALLOC);
   // (RL3) truncate, no error
   assign id_xfer       = clip({1'b0, nv_id_len} + {1'b0, `ID_HDR_LEN}, alloc_len);
   // (RL12) whole entries that fit
   assign lun_xfer      = clip({1'b0, `LUN_DATA_LEN}, alloc_len);

   assign load      = (state_q == ST_SEND) && (!dout_valid_q || dout_ready)
                      && (idx_q < xfer_len_q);
   assign done_send = dout_valid_q && dout_ready && dout_last_q;

   // (RL8) one store, no port select
   assign nv_rd_addr = idx_q - `ID_HDR_LEN;

   always_comb begin
      next_byte = 8'h00;
      if (kind_q == K_ID) begin
         // (RL1) (RL4) identifier data bytes
         next_byte = (idx_q < `ID_HDR_LEN) ? msb_byte(id_len_q, idx_q[1:0]) : nv_rd_data;
      end else if (idx_q < `ID_HDR_LEN) begin
         // (RL13) list length eight
         next_byte = msb_byte(`LUN_LIST_LEN, idx_q[1:0]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q    <= ST_IDLE;
         kind_q     <= K_NONE;
         idx_q      <= 32'h0000_0000;
         xfer_len_q <= 32'h0000_0000;
         id_len_q   <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               idx_q <= 32'h0000_0000;
               if (cdb_done && is_id) begin
                  kind_q <= K_ID;
                  if (id_lun_bad || !nv_ready) begin
                     state_q <= ST_STAT;
                  end else begin
                     // (RL5) (RL6) (RL7) stored length kept
                     id_len_q   <= nv_id_len;
                     xfer_len_q <= id_xfer;
                     state_q    <= (id_xfer == 32'h0000_0000) ? ST_STAT : ST_SEND;
                  end
               end else if (cdb_done && is_lun) begin
                  kind_q     <= K_LUN;
                  xfer_len_q <= lun_xfer;
                  state_q    <= lun_alloc_bad ? ST_STAT : ST_SEND;
               end
            end
            ST_SEND: begin
               if (load) begin
                  idx_q <= idx_q + 32'h0000_0001;
               end
               if (done_send) begin
                  state_q <= ST_STAT;
               end
            end
            ST_STAT: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout_valid_q <= 1'b0;
         dout_byte_q  <= 8'h00;
         dout_last_q  <= 1'b0;
         out_idx_q    <= 32'h0000_0000;
      end else if (load) begin
         dout_valid_q <= 1'b1;
         dout_byte_q  <= next_byte;
         dout_last_q  <= (idx_q == xfer_len_q - 32'h0000_0001);
         out_idx_q    <= idx_q;
      end else if (dout_ready) begin
         dout_valid_q <= 1'b0;
         dout_last_q  <= 1'b0;
      end
   end

   // Status is latched at decode; sending never alters it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sts_code_q <= `STS_GOOD;
         key_q      <= `KEY_NONE;
         asc_q      <= `ASC_NONE;
         ascq_q     <= `ASC_NONE;
      end else if (state_q == ST_IDLE && cdb_done) begin
         sts_code_q <= `STS_GOOD;
         key_q      <= `KEY_NONE;
         asc_q      <= `ASC_NONE;
         ascq_q     <= `ASC_NONE;
         if ((is_id && id_lun_bad) || (is_lun && lun_alloc_bad)) begin
            sts_code_q <= `STS_CHECK;
            key_q      <= `KEY_ILLEGAL;
            asc_q      <= `ASC_INV_FIELD;
            ascq_q     <= `ASCQ_INV_FIELD;
         end else if (is_id && !nv_ready) begin
            // (RL9) not ready, no wait
            sts_code_q <= `STS_CHECK;
            key_q      <= `KEY_NOT_READY;
            asc_q      <= NR_ASC;
            ascq_q     <= NR_ASCQ;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         foreign_q <= 1'b0;
      end else begin
         foreign_q <= (state_q == ST_IDLE) && cdb_done && !is_id && !is_lun;
      end
   end

   assign foreign_cmd = foreign_q;
   assign dout_valid  = dout_valid_q;
   assign dout_byte   = dout_byte_q;
   assign dout_last   = dout_last_q;
   // (RL15) status phase
   assign sts_valid   = (state_q == ST_STAT);
   assign sts_code    = sts_code_q;
   assign sense_key   = key_q;
   assign sense_asc   = asc_q;
   assign sense_ascq  = ascq_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_decode_id;
      (state_q == ST_IDLE) && cdb_done && is_id;
   endsequence

   sequence s_send_end;
      dout_valid_q && dout_ready && dout_last_q;
   endsequence

   property p_lun_bad;
      s_decode_id ##0 id_lun_bad |=> sts_valid && sts_code == `STS_CHECK
                                      && sense_key == `KEY_ILLEGAL;
   endproperty
   a_lun_bad: assert property (p_lun_bad) else $error("Bad LUN not rejected."); // RL2

   property p_not_ready;
      s_decode_id ##0 (!id_lun_bad && !nv_ready) |=> sts_valid
                      && sense_key == `KEY_NOT_READY && !dout_valid;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("Not ready not reported."); // RL9

   property p_list_alloc;
      (state_q == ST_IDLE) && cdb_done && is_lun && lun_alloc_bad
         |=> sts_valid && sense_key == `KEY_ILLEGAL && sense_asc == `ASC_INV_FIELD;
   endproperty
   a_list_alloc: assert property (p_list_alloc) else $error("Short list alloc accepted."); // RL11

   property p_len_byte;
      dout_valid && kind_q == K_ID && out_idx_q < `ID_HDR_LEN
         |-> dout_byte == msb_byte(id_len_q, out_idx_q[1:0]);
   endproperty
   a_len_byte: assert property (p_len_byte) else $error("Identifier length byte wrong."); // RL4

   property p_list_bytes;
      dout_valid && kind_q == K_LUN
         |-> dout_byte == ((out_idx_q == 32'h0000_0003) ? 8'h08 : 8'h00);
   endproperty
   a_list_bytes: assert property (p_list_bytes) else $error("LUN list byte wrong."); // RL13

   property p_trunc;
      dout_valid && dout_last |-> out_idx_q == xfer_len_q - 32'h0000_0001
                                  && xfer_len_q <= alloc_len;
   endproperty
   a_trunc: assert property (p_trunc) else $error("Transfer length wrong."); // RL3

   property p_good;
      s_send_end |=> sts_valid && sts_code == `STS_GOOD ##1 !sts_valid;
   endproperty
   a_good: assert property (p_good) else $error("Good status missing."); // RL15

   property p_full_len;
      (state_q == ST_SEND) && ($past(state_q) == ST_SEND) && kind_q == K_ID
         |-> $stable(id_len_q) && xfer_len_q <= id_len_q + `ID_HDR_LEN;
   endproperty
   a_full_len: assert property (p_full_len) else $error("Length altered in send."); // RL5

endmodule // report_engine

// file: testbench/id_store_model.sv
`timescale 1ns/1ps

module id_store_model (
   input  wire logic [31:0] len_set,
   input  wire logic        rdy_set,
   output logic             nv_ready,
   output logic [31:0]      nv_id_len,
   input  wire logic [31:0] nv_rd_addr,
   output logic [7:0]       nv_rd_data
);
   // stored length kept
   // The store has no reset, so a block reset leaves its contents alone.
   assign nv_id_len = len_set;
   assign nv_ready  = rdy_set;
   // one identifier
   // Each of the first 256 addresses gives a distinct byte, so a misplaced index shows up.
   assign nv_rd_data = nv_rd_addr[7:0] ^ 8'hA5 ^ {nv_rd_addr[10:8], 5'h00};
endmodule // id_store_model

// file: testbench/scsi_identifier_lun_report_test.sv
`timescale 1ns/1ps
`include "report_consts.svh"

module scsi_identifier_lun_report_test;
   logic        clk        = 1'b0;
   logic        rst        = 1'b1;
   logic        cdb_valid  = 1'b0;
   logic [7:0]  cdb_byte   = 8'h00;
   logic        dout_ready = 1'b0;
   logic        rdy_set    = 1'b1;
   logic [31:0] len_set    = 32'h0000_0000;
   logic [31:0] rng        = 32'h0000_a3d7;
   logic        cdb_ready, foreign_cmd, nv_ready, dout_valid, dout_last, sts_valid;
   logic [31:0] nv_id_len, nv_rd_addr;
   logic [7:0]  nv_rd_data, dout_byte, sts_code, sense_asc, sense_ascq, r;
   logic [3:0]  sense_key;
   int          n_mismatch = 0;
   int          checked    = 0;
   int          n_test     = 0;

   always #12.5 clk = ~clk;

   id_store_model i_store (.len_set(len_set), .rdy_set(rdy_set), .nv_ready(nv_ready),
      .nv_id_len(nv_id_len), .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data));

   report_engine i_dut (.clk(clk), .rst(rst), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
      .cdb_ready(cdb_ready), .foreign_cmd(foreign_cmd), .nv_ready(nv_ready),
      .nv_id_len(nv_id_len), .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data),
      .dout_valid(dout_valid), .dout_byte(dout_byte), .dout_last(dout_last),
      .dout_ready(dout_ready), .sts_valid(sts_valid), .sts_code(sts_code),
      .sense_key(sense_key), .sense_asc(sense_asc), .sense_ascq(sense_ascq));

   function automatic logic [7:0] xb();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction

   function automatic logic [7:0] exp_byte(logic is_id, logic [31:0] idx, logic [31:0] len);
      logic [31:0] a;
      a = idx - 32'h0000_0004;
      if (!is_id) return (idx == 32'h0000_0003) ? 8'h08 : 8'h00;
      if (idx < 32'h0000_0004) return len[8*(3-idx[1:0]) +: 8];
      return a[7:0] ^ 8'hA5 ^ {a[10:8], 5'h00};
   endfunction

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_data(logic [31:0] got, logic [31:0] exp);
      chk(got, exp);
   endtask

   task automatic chk_sts(logic [31:0] exp);
      chk({sts_code, 4'h0, sense_key, sense_asc, sense_ascq}, exp);
   endtask

   task automatic chk_count(logic [31:0] got, logic [31:0] exp);
      chk(got, exp);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk_count({31'h0, cdb_ready}, 32'h0000_0001);
      rst = 1'b0;
   endtask

   task automatic run(logic [7:0] op, logic [7:0] b1, logic [15:0] lun, logic [31:0] alloc);
      logic [7:0]  b[12];
      logic        is_id, is_lun, fgn, seen_f, done;
      logic [31:0] n, want, sx, ex;
      int          k;
      b = '{op, b1, xb(), xb(), lun[15:8], lun[7:0], alloc[31:24], alloc[23:16],
            alloc[15:8], alloc[7:0], xb(), xb()};
      is_id  = (op == `OP_IDENT) && (b1[4:0] == `SA_IDENT);
      is_lun = (op == `OP_LUNS);
      fgn    = !is_id && !is_lun;
      want   = 32'h0000_0000;
      sx     = {`STS_GOOD, 4'h0, `KEY_NONE, `ASC_NONE, 8'h00};
      if ((is_id && lun != 16'h0000) || (is_lun && alloc < `LUN_MIN_ALLOC))
         sx = {`STS_CHECK, 4'h0, `KEY_ILLEGAL, `ASC_INV_FIELD, `ASCQ_INV_FIELD};
      else if (is_id && !rdy_set) sx = {`STS_CHECK, 4'h0, `KEY_NOT_READY, 8'h04, 8'h00};
      else if (is_id) want = (alloc < len_set + `ID_HDR_LEN) ? alloc : len_set + `ID_HDR_LEN;
      else if (is_lun) want = `LUN_DATA_LEN;
      for (k = 0; k < 12; k++) begin
         @(negedge clk);
         cdb_valid = 1'b1;
         cdb_byte  = b[k];
         while (!cdb_ready) @(negedge clk);
      end
      n = 32'h0000_0000;
      done = 1'b0;
      seen_f = 1'b0;
      for (k = 0; k < (fgn ? 40 : 400) && !done; k++) begin
         @(negedge clk);
         cdb_valid = 1'b0;
         // Random stalls check that each byte stands until it is taken.
         dout_ready = (xb() > 8'h50);
         if (dout_valid && dout_ready) begin
            ex = {23'h0, n + 1 == want, exp_byte(is_id, n, len_set)};
            chk_data({23'h0, dout_last, dout_byte}, ex);
            n++;
         end
         if (foreign_cmd) seen_f = 1'b1;
         if (sts_valid) begin
            chk_sts(sx);
            done = 1'b1;
         end
      end
      chk_count(n, want);
      chk_count({30'h0, done, seen_f}, {30'h0, !fgn, fgn});
      n_test++;
      $display("test %0d done", n_test);
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      summarize();
   end

   initial begin
      do_reset();
      len_set = 32'h0000_000a;
      run(`OP_IDENT, 8'hE5, 16'h0000, 32'h0000_0100);
      run(`OP_IDENT, 8'h05, 16'h0000, 32'h0000_0006);
      run(`OP_IDENT, 8'h05, 16'h0000, 32'h0000_0000);
      run(`OP_IDENT, 8'h05, 16'h0100, 32'h0000_0040);
      run(`OP_IDENT, 8'h05, 16'h0001, 32'h0000_0040);
      rdy_set = 1'b0;
      run(`OP_IDENT, 8'h05, 16'h0000, 32'h0000_0040);
      rdy_set = 1'b1;
      len_set = 32'h0000_0000;
      run(`OP_IDENT, 8'h05, 16'h0000, 32'h0000_0040);
      run(`OP_LUNS, 8'hFF, 16'hFFFF, 32'h0000_0010);
      run(`OP_LUNS, 8'h00, 16'h0000, 32'h0000_000f);
      run(`OP_LUNS, 8'h00, 16'h0000, 32'hffff_ffff);
      run(8'hA3, 8'h0C, 16'h0000, 32'h0000_0040);
      run(8'h12, 8'h05, 16'h0000, 32'h0000_0040);
      len_set = 32'h0000_0007;
      do_reset();
      run(`OP_IDENT, 8'h05, 16'h0000, 32'h0000_0040);
      repeat (30) begin
         r = xb();
         len_set = {24'h0, xb() & 8'h1f};
         rdy_set = (xb() > 8'h20);
         run((r[1:0] == 2'b00) ? `OP_LUNS : (r[1:0] == 2'b11) ? xb() : `OP_IDENT,
             r[2] ? 8'h05 : xb(), {15'h0, xb() > 8'hE0}, {24'h0, xb()});
      end
      summarize();
   end
endmodule // scsi_identifier_lun_report_test
